/* File: common/ebwsg_pkg.sv */
// Constants, types and helpers shared by the external bus wait-state generator
package ebwsg_pkg;

	// Register byte offsets on the AHB-Lite slave
	localparam logic [7:0] EBWSG_OFS_CONFIG = 8'h00;
	localparam logic [7:0] EBWSG_OFS_MULT   = 8'h04;
	localparam logic [7:0] EBWSG_OFS_STATUS = 8'h08;

	// Reset values; every field starts at seven waits, its largest value, with the doubler off
	localparam logic [15:0] EBWSG_CONFIG_RST = 16'h7FFF;
	localparam logic [15:0] EBWSG_MULT_RST   = 16'h0000;

	// Field positions inside wait_state_config
	localparam int unsigned EBWSG_IO_LSB    = 12;
	localparam int unsigned EBWSG_DHI_LSB   = 9;
	localparam int unsigned EBWSG_DLO_LSB   = 6;
	localparam int unsigned EBWSG_PHI_LSB   = 3;
	localparam int unsigned EBWSG_PLO_LSB   = 0;
	localparam int unsigned EBWSG_XPA_BIT   = 15;
	localparam int unsigned EBWSG_FIELD_W   = 3;
	localparam int unsigned EBWSG_CNT_W     = 4;

	// Field position inside wait_state_multiplier_ctrl
	localparam int unsigned EBWSG_DBL_BIT   = 0;

	// Status register bit positions
	localparam int unsigned EBWSG_ST_BUSY   = 0;
	localparam int unsigned EBWSG_ST_FLAG   = 1;
	localparam int unsigned EBWSG_ST_READY  = 2;
	localparam int unsigned EBWSG_ST_MSC    = 3;
	localparam int unsigned EBWSG_ST_CNT    = 4;

	// Fewest software wait states for which the ready pin is looked at
	localparam logic [3:0] EBWSG_MIN_HW_WS = 4'h2;

	typedef enum logic [1:0] {
		EBWSG_SP_PROG,
		EBWSG_SP_DATA,
		EBWSG_SP_IO
	} ebwsg_space_t;

	function automatic logic [2:0] ebwsg_field(input logic [15:0] cfg, input int unsigned lsb);
		logic [15:0] sh;
		sh = cfg >> lsb;
		return sh[2:0];
	endfunction

endpackage

/* File: hw/ebwsg_wait_select.sv */
// Picks the wait-state count for an access from space, address and config
`timescale 1ns/1ps
module ebwsg_wait_select
	import ebwsg_pkg::*;
#(
	parameter bit SUPPORTS_XPA     = 1'b1,
	parameter bit SUPPORTS_DOUBLER = 1'b1
) (
	input  wire logic [15:0] cfg,
	input  wire logic        doubler,
	input  wire ebwsg_space_t space,
	input  wire logic        addr_msb,
	input  wire logic        prog_ext_msb,
	output logic      [3:0]  wait_count
);

	logic [2:0] field;
	logic       prog_hi;

	always_comb begin
		// With the extended range bit set, the page bit above the 16-bit address splits the halves
		prog_hi = (SUPPORTS_XPA && cfg[EBWSG_XPA_BIT]) ? prog_ext_msb : addr_msb; // RL15
		case (space)
			EBWSG_SP_IO: begin
				field = ebwsg_field(cfg, EBWSG_IO_LSB); // RL9 RL16
			end
			EBWSG_SP_DATA: begin
				field = addr_msb ? ebwsg_field(cfg, EBWSG_DHI_LSB) // RL10 RL16
					: ebwsg_field(cfg, EBWSG_DLO_LSB); // RL11
			end
			EBWSG_SP_PROG: begin
				field = prog_hi ? ebwsg_field(cfg, EBWSG_PHI_LSB) // RL12 RL16
					: ebwsg_field(cfg, EBWSG_PLO_LSB); // RL13
			end
			default: begin
				field = 3'h0;
			end
		endcase
		if (SUPPORTS_DOUBLER && doubler) begin
			wait_count = {field, 1'b0}; // RL14
		end else begin
			wait_count = {1'b0, field}; // RL8
		end
	end

endmodule

/* File: hw/ebwsg_bus_if.sv */
// External bus strobe, direction, wait-state and flag logic with AHB-Lite registers
//
// Our own choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
// Functional notes
// RL1 - I/O strobe low only during I/O access
// RL2 - Direction high, low only during writes
// RL3 - Ready low stalls one cycle, resample
// RL4 - Ready looked at only after two+ waits
// RL5 - Microstate low first wait to last wait
// RL6 - Microstate looped to ready adds one wait
// RL7 - Flag set, cleared by clear or load
// RL8 - Field value gives zero to seven waits
// RL9 - Bits 14:12 govern all I/O space
// RL10 - Bits 11:9 govern upper data half
// RL11 - Bits 8:6 govern lower data half
// RL12 - Bits 5:3 govern upper program half
// RL13 - Bits 2:0 govern lower program half
// RL14 - Doubler bit doubles every wait count
// RL15 - Top bit picks program field ranges
// RL16 - Two halves per memory space, one I/O
// RL17 - Slow device holds ready low until done
// RL18 - Count chosen at access start, counted down
module ebwsg_bus_if
	import ebwsg_pkg::*;
#(
	parameter bit SUPPORTS_XPA     = 1'b1,
	parameter bit SUPPORTS_DOUBLER = 1'b1
) (
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	input  wire logic        ce,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic      [31:0] hrdata,
	output logic             hresp,
	input  wire logic        acc_req,
	input  wire ebwsg_space_t acc_space,
	input  wire logic [15:0] acc_addr,
	input  wire logic        acc_prog_ext_msb,
	input  wire logic        acc_write,
	input  wire logic [15:0] acc_wdata,
	output logic             acc_busy,
	output logic             acc_done,
	output logic      [15:0] acc_rdata,
	input  wire logic        set_status_bit_instr,
	input  wire logic        clear_status_bit_instr,
	input  wire logic        status_register_one_load,
	output logic      [15:0] ext_addr,
	output logic      [15:0] ext_data_out,
	output logic             ext_data_oe,
	input  wire logic [15:0] ext_data_in,
	output logic             io_space_strobe_n,
	output logic             prog_strobe_n,
	output logic             data_strobe_n,
	output logic             read_write_n,
	input  wire logic        ready_in,
	output logic             microstate_done_out,
	output logic             latched_flag_out
);

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ACCESS,
		ST_WAIT,
		ST_HWAIT
	} ebwsg_state_t;

	ebwsg_state_t state;
	logic [15:0]  wait_state_config;
	logic [15:0]  wait_state_multiplier_ctrl;
	logic [3:0]   sel_count;
	logic [3:0]   ws_total;
	logic [3:0]   cnt;
	logic         write_q;
	logic         ready_s1;
	logic         ready_s2;
	logic [15:0]  data_s1;
	logic [15:0]  data_s2;
	logic         finish;
	logic         start;
	logic         ap_take;
	logic         dp_write;
	logic [7:0]   dp_addr;
	logic [15:0]  status_word;

	ebwsg_wait_select #(
		.SUPPORTS_XPA     (SUPPORTS_XPA),
		.SUPPORTS_DOUBLER (SUPPORTS_DOUBLER)
	) u_select (
		.cfg          (wait_state_config),
		.doubler      (wait_state_multiplier_ctrl[EBWSG_DBL_BIT]),
		.space        (acc_space),
		.addr_msb     (acc_addr[15]),
		.prog_ext_msb (acc_prog_ext_msb),
		.wait_count   (sel_count)
	);

	// Pins from the far side pass two flops before anything looks at them
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			ready_s1 <= 1'b1;
			ready_s2 <= 1'b1;
			data_s1  <= 16'h0000;
			data_s2  <= 16'h0000;
		end else if (ce) begin
			ready_s1 <= ready_in;
			ready_s2 <= ready_s1;
			data_s1  <= ext_data_in;
			data_s2  <= data_s1;
		end
	end
	assign acc_busy = (state != ST_IDLE);
	assign start    = ce && (state == ST_IDLE) && acc_req;

	always_comb begin
		finish = 1'b0;
		if (ce) begin
			case (state)
				ST_ACCESS: begin
					finish = (ws_total == 4'h0);
				end
				ST_WAIT: begin
					finish = (cnt == 4'h1) && (ws_total < EBWSG_MIN_HW_WS); // RL4
				end
				ST_HWAIT: begin
					finish = ready_s2; // RL3 RL17
				end
				default: begin
					finish = 1'b0;
				end
			endcase
		end
	end

	// Access sequencer
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			state    <= ST_IDLE;
			ws_total <= 4'h0;
			cnt      <= 4'h0;
		end else if (ce) begin
			case (state)
				ST_IDLE: begin
					if (acc_req) begin
						state    <= ST_ACCESS;
						ws_total <= sel_count; // RL18 RL8
					end
				end
				ST_ACCESS: begin
					if (ws_total == 4'h0) begin
						state <= ST_IDLE;
					end else begin
						state <= ST_WAIT;
						cnt   <= ws_total; // RL18
					end
				end
				ST_WAIT: begin
					if (cnt == 4'h1) begin
						// Ready is only checked once the software waits have run out
						state <= (ws_total >= EBWSG_MIN_HW_WS) ? ST_HWAIT : ST_IDLE; // RL4
					end
					cnt <= cnt - 4'h1; // RL18
				end
				ST_HWAIT: begin
					if (ready_s2) begin
						state <= ST_IDLE; // RL3
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// External pins, held from the access start until its finish
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			io_space_strobe_n <= 1'b1;
			prog_strobe_n     <= 1'b1;
			data_strobe_n     <= 1'b1;
			read_write_n      <= 1'b1;
			ext_addr          <= 16'h0000;
			ext_data_out      <= 16'h0000;
			ext_data_oe       <= 1'b0;
			write_q           <= 1'b0;
		end else if (start) begin
			io_space_strobe_n <= (acc_space != EBWSG_SP_IO); // RL1
			prog_strobe_n     <= (acc_space != EBWSG_SP_PROG);
			data_strobe_n     <= (acc_space != EBWSG_SP_DATA);
			read_write_n      <= !acc_write; // RL2
			ext_addr          <= acc_addr;
			ext_data_out      <= acc_wdata;
			ext_data_oe       <= acc_write;
			write_q           <= acc_write;
		end else if (finish) begin
			io_space_strobe_n <= 1'b1; // RL1
			prog_strobe_n     <= 1'b1;
			data_strobe_n     <= 1'b1;
			read_write_n      <= 1'b1; // RL2
			ext_data_oe       <= 1'b0;
		end
	end

	// Microstate output: low from the first software wait until the last one begins
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			microstate_done_out <= 1'b1;
		end else if (ce) begin
			if (state == ST_ACCESS && ws_total >= EBWSG_MIN_HW_WS) begin
				microstate_done_out <= 1'b0; // RL5
			end else if (state == ST_WAIT && cnt == 4'h2) begin
				microstate_done_out <= 1'b1; // RL5 RL6
			end
		end
	end

	// Result to the core; read data is taken from the synchronised bus
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			acc_done  <= 1'b0;
			acc_rdata <= 16'h0000;
		end else if (ce) begin
			acc_done <= finish;
			if (finish && !write_q) begin
				acc_rdata <= data_s2;
			end
		end
	end

	// Latched flag; a set in the same cycle as a clear wins
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			latched_flag_out <= 1'b0;
		end else if (ce) begin
			if (set_status_bit_instr) begin
				latched_flag_out <= 1'b1; // RL7
			end else if (clear_status_bit_instr || status_register_one_load) begin
				latched_flag_out <= 1'b0; // RL7
			end
		end
	end

	// AHB-Lite slave: no wait states while enabled, stalls while frozen
	assign hreadyout = ce;
	assign hresp     = 1'b0;
	assign ap_take   = ce && hsel && htrans[1] && hready;
	always_comb begin
		status_word = 16'h0000;
		status_word[EBWSG_ST_BUSY]  = acc_busy;
		status_word[EBWSG_ST_FLAG]  = latched_flag_out;
		status_word[EBWSG_ST_READY] = ready_s2;
		status_word[EBWSG_ST_MSC]   = microstate_done_out;
		status_word[EBWSG_ST_CNT +: EBWSG_CNT_W] = cnt;
	end
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			dp_write <= 1'b0;
			dp_addr  <= 8'h00;
			hrdata   <= 32'h0000_0000;
		end else if (ce) begin
			dp_write <= ap_take && hwrite;
			if (ap_take) begin
				dp_addr <= haddr[7:0];
			end
			// Read data is fetched in the address phase, so a read just after a write sees the old value
			if (ap_take && !hwrite) begin
				case (haddr[7:0])
					EBWSG_OFS_CONFIG: hrdata <= {16'h0000, wait_state_config};
					EBWSG_OFS_MULT:   hrdata <= {16'h0000, wait_state_multiplier_ctrl};
					EBWSG_OFS_STATUS: hrdata <= {16'h0000, status_word};
					default:          hrdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Reserved bits are never stored and read back as zero
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			wait_state_config          <= EBWSG_CONFIG_RST;
			wait_state_multiplier_ctrl <= EBWSG_MULT_RST;
		end else if (ce && dp_write) begin
			if (dp_addr == EBWSG_OFS_CONFIG) begin
				wait_state_config <= hwdata[15:0];
				wait_state_config[EBWSG_XPA_BIT] <= SUPPORTS_XPA && hwdata[EBWSG_XPA_BIT]; // RL15
			end
			if (dp_addr == EBWSG_OFS_MULT) begin
				wait_state_multiplier_ctrl <= 16'h0000;
				wait_state_multiplier_ctrl[EBWSG_DBL_BIT] <=
					SUPPORTS_DOUBLER && hwdata[EBWSG_DBL_BIT]; // RL14
			end
		end
	end

	// Checks
	sequence s_sw_waits3;
		(state == ST_WAIT)[*3];
	endsequence
	sequence s_msc_low_run;
		!microstate_done_out ##1 !microstate_done_out;
	endsequence
	property p_io_strobe;
		@(posedge sys_clk) disable iff (!rstn || !ce)
		!io_space_strobe_n |-> (state != ST_IDLE) && prog_strobe_n && data_strobe_n;
	endproperty
	a_io_strobe: assert property (p_io_strobe) else $error("io strobe low while idle"); // RL1
	property p_io_start;
		@(posedge sys_clk) disable iff (!rstn || !ce)
		start && acc_space == EBWSG_SP_IO |=> !io_space_strobe_n && prog_strobe_n;
	endproperty
	a_io_start: assert property (p_io_start) else $error("io strobe not asserted"); // RL1
	property p_dir;
		@(posedge sys_clk) disable iff (!rstn || !ce)
		!read_write_n |-> write_q && acc_busy;
	endproperty
	a_dir: assert property (p_dir) else $error("direction low outside write"); // RL2
	property p_stall;
		@(posedge sys_clk) disable iff (!rstn || !ce)
		state == ST_HWAIT && !ready_s2 |=> state == ST_HWAIT && !acc_done;
	endproperty
	a_stall: assert property (p_stall) else $error("ready low did not stall"); // RL3
	property p_no_ready_short;
		@(posedge sys_clk) disable iff (!rstn || !ce)
		state == ST_ACCESS && ws_total == 4'h1 |=> state == ST_WAIT ##1 state == ST_IDLE;
	endproperty
	a_no_ready_short: assert property (p_no_ready_short) else $error("ready used below two"); // RL4
	property p_msc_window;
		@(posedge sys_clk) disable iff (!rstn || !ce)
		state == ST_ACCESS && ws_total == 4'h3 |=> s_msc_low_run ##1 microstate_done_out;
	endproperty
	a_msc_window: assert property (p_msc_window) else $error("microstate timing wrong"); // RL5
	property p_len3;
		@(posedge sys_clk) disable iff (!rstn || !ce)
		state == ST_ACCESS && ws_total == 4'h3 |=> s_sw_waits3 ##1 state == ST_HWAIT;
	endproperty
	a_len3: assert property (p_len3) else $error("three waits then ready check"); // RL6 RL8
	property p_flag;
		@(posedge sys_clk) disable iff (!rstn || !ce)
		(set_status_bit_instr |=> latched_flag_out) and
		(!set_status_bit_instr && status_register_one_load |=> !latched_flag_out);
	endproperty
	a_flag: assert property (p_flag) else $error("flag did not follow instruction"); // RL7
	property p_load;
		@(posedge sys_clk) disable iff (!rstn || !ce)
		start |=> state == ST_ACCESS && ws_total == $past(sel_count);
	endproperty
	a_load: assert property (p_load) else $error("wait count not loaded"); // RL18
	property p_io_field;
		@(posedge sys_clk) disable iff (!rstn || !ce)
		start && acc_space == EBWSG_SP_IO && !wait_state_multiplier_ctrl[EBWSG_DBL_BIT]
		|=> ws_total == {1'b0, $past(wait_state_config[14:12])};
	endproperty
	a_io_field: assert property (p_io_field) else $error("io field not used"); // RL9
	property p_double;
		@(posedge sys_clk) disable iff (!rstn || !ce)
		start && wait_state_multiplier_ctrl[EBWSG_DBL_BIT] |=> ws_total[0] == 1'b0;
	endproperty
	a_double: assert property (p_double) else $error("doubled count is odd"); // RL14

endmodule

/* File: testbench/ebwsg_ext_dev.sv */
// Behavioural external memory or I/O device on the far side of the bus
`timescale 1ns/1ps
module ebwsg_ext_dev (
	input  wire logic        sys_clk,
	input  wire logic        sel_n,
	input  wire logic        read_write_n,
	input  wire logic        microstate_done_out,
	input  wire logic        loop_en,
	input  wire logic [3:0]  stall_cycles,
	input  wire logic [15:0] rd_value,
	output logic             ready_in,
	output logic      [15:0] ext_data_in
);
	logic [3:0] busy_cnt = 4'h0;
	// Saturates so a long stall is never cut short by wrap-around
	always_ff @(posedge sys_clk) begin
		if (sel_n)
			busy_cnt <= 4'h0;
		else if (busy_cnt != 4'hF)
			busy_cnt <= busy_cnt + 4'h1;
	end
	assign ready_in = loop_en ? microstate_done_out : (busy_cnt >= stall_cycles);
	// Released bus shows the inverse, so stale data never looks valid
	assign ext_data_in = (!sel_n && read_write_n) ? rd_value : ~rd_value;
endmodule

/* File: testbench/external_bus_wait_state_gen_tb.sv */
// Self-checking bench for the external bus wait-state generator
`timescale 1ns/1ps
module external_bus_wait_state_gen_tb;
	import ebwsg_pkg::*;
	localparam logic [15:0] RDV = 16'h3C5A;
	localparam logic [15:0] WDV = 16'hA5C3;
	logic         sys_clk = 1'b0;
	logic         rstn = 1'b0;
	logic         ce = 1'b1;
	logic         hsel = 1'b0;
	logic [31:0]  haddr = 32'h0;
	logic [1:0]   htrans = 2'h0;
	logic         hwrite = 1'b0;
	logic [31:0]  hwdata = 32'h0;
	logic         acc_req = 1'b0;
	ebwsg_space_t acc_space = EBWSG_SP_PROG;
	logic [15:0]  acc_addr = 16'h0;
	logic         xmsb = 1'b0;
	logic         acc_write = 1'b0;
	logic [2:0]   fl = 3'h0;
	logic         loop_en = 1'b0;
	logic [3:0]   stall = 4'h0;
	logic [31:0]  hrdata;
	logic [31:0]  d;
	logic [15:0]  acc_rdata, ext_addr, ext_data_out, ext_data_in;
	logic         hreadyout, hresp, acc_done, acc_busy, ext_data_oe, ready_in;
	logic         io_space_strobe_n, prog_strobe_n, data_strobe_n;
	logic         read_write_n, microstate_done_out, latched_flag_out;
	int           err_count = 0;
	int           comparisons = 0;

	always #12.5 sys_clk = ~sys_clk;

	ebwsg_bus_if u_dut (
		.sys_clk(sys_clk), .rstn(rstn), .ce(ce), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.acc_req(acc_req), .acc_space(acc_space), .acc_addr(acc_addr),
		.acc_prog_ext_msb(xmsb), .acc_write(acc_write), .acc_wdata(WDV), .acc_busy(acc_busy),
		.acc_done(acc_done), .acc_rdata(acc_rdata), .set_status_bit_instr(fl[0]),
		.clear_status_bit_instr(fl[1]), .status_register_one_load(fl[2]),
		.ext_addr(ext_addr), .ext_data_out(ext_data_out), .ext_data_oe(ext_data_oe),
		.ext_data_in(ext_data_in), .io_space_strobe_n(io_space_strobe_n),
		.prog_strobe_n(prog_strobe_n), .data_strobe_n(data_strobe_n),
		.read_write_n(read_write_n), .ready_in(ready_in),
		.microstate_done_out(microstate_done_out), .latched_flag_out(latched_flag_out)
	);

	ebwsg_ext_dev u_dev (
		.sys_clk(sys_clk), .sel_n(io_space_strobe_n & prog_strobe_n & data_strobe_n),
		.read_write_n(read_write_n), .microstate_done_out(microstate_done_out),
		.loop_en(loop_en), .stall_cycles(stall), .rd_value(RDV), .ready_in(ready_in),
		.ext_data_in(ext_data_in)
	);

	task automatic test_done();
		if (err_count == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// Hangs on a stuck hready are cut short here
	task automatic edge_rdy();
		for (int i = 0; i < 50; i++) begin
			@(posedge sys_clk);
			if (hreadyout === 1'b1)
				return;
		end
		err_count++;
		test_done();
	endtask

	task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd);
		@(posedge sys_clk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		edge_rdy();
		htrans <= 2'h0;
		hwdata <= wd;
		edge_rdy();
		d = hrdata;
	endtask

	function automatic int ex(input int n, input int s);
		if (n < 2)
			return n + 2;
		return ((n + 2 > s + 3) ? n + 2 : s + 3) + 1;
	endfunction

	task automatic acc(input ebwsg_space_t sp, input logic [15:0] a, input logic w, input int n);
		int c;
		int lo;
		// Cycle 1 is the one after the edge that takes the request
		c = 1;
		lo = 0;
		@(posedge sys_clk);
		acc_req <= 1'b1;
		acc_space <= sp;
		acc_addr <= a;
		acc_write <= w;
		@(posedge sys_clk);
		acc_req <= 1'b0;
		do begin
			@(posedge sys_clk);
			#1;
			c++;
			if (acc_done !== 1'b1) begin
				chk(io_space_strobe_n, sp != EBWSG_SP_IO);
				chk({prog_strobe_n, data_strobe_n}, {sp != EBWSG_SP_PROG, sp != EBWSG_SP_DATA});
				chk(read_write_n, !w);
				chk({acc_busy, ext_data_oe}, {1'b1, w});
				chk(ext_addr, a);
				if (w)
					chk(ext_data_out, WDV);
				lo += (microstate_done_out === 1'b0);
			end
		end while (acc_done !== 1'b1 && c < 40);
		if (c >= 40) begin
			err_count++;
			test_done();
		end
		chk(c, loop_en ? n + 4 : ex(n, stall));
		chk(lo, (n >= 2) ? n - 1 : 0);
		chk({io_space_strobe_n, read_write_n}, 2'b11);
		chk({prog_strobe_n, data_strobe_n, acc_busy, ext_data_oe}, 4'hC);
		if (!w && n >= 2)
			chk(acc_rdata, RDV);
	endtask

	task automatic flag(input logic [2:0] k, input logic e);
		@(posedge sys_clk);
		fl <= k;
		@(posedge sys_clk);
		fl <= 3'h0;
		#1;
		chk(latched_flag_out, e);
	endtask

	// Clock enable low must freeze the flag and stall the register bus
	task automatic freeze();
		@(posedge sys_clk);
		ce <= 1'b0;
		fl <= 3'h1;
		@(posedge sys_clk);
		fl <= 3'h0;
		#1;
		chk({hreadyout, latched_flag_out}, 2'b00);
		@(posedge sys_clk);
		ce <= 1'b1;
	endtask

	initial begin
		repeat (3) @(posedge sys_clk);
		rstn <= 1'b1;
		#1;
		chk({io_space_strobe_n, read_write_n, microstate_done_out, latched_flag_out}, 4'hE);
		ahb(EBWSG_OFS_CONFIG, 1'b0, 32'h0);
		chk(d, {16'h0, EBWSG_CONFIG_RST});
		ahb(EBWSG_OFS_MULT, 1'b0, 32'h0);
		chk(d, {16'h0, EBWSG_MULT_RST});
		ahb(8'h0C, 1'b1, 32'hFFFF);
		ahb(8'h0C, 1'b0, 32'h0);
		chk(d, 32'h0);
		chk(hresp, 1'b0);
		ahb(EBWSG_OFS_CONFIG, 1'b1, 32'h272E);
		ahb(EBWSG_OFS_CONFIG, 1'b0, 32'h0);
		chk(d, 32'h272E);
		acc(EBWSG_SP_IO, 16'h8000, 1'b0, 2);
		acc(EBWSG_SP_DATA, 16'h8000, 1'b1, 3);
		acc(EBWSG_SP_DATA, 16'h7FFF, 1'b0, 4);
		acc(EBWSG_SP_PROG, 16'hFFFF, 1'b0, 5);
		acc(EBWSG_SP_PROG, 16'h0000, 1'b1, 6);
		for (int m = 0; m < 2; m++) begin
			ahb(EBWSG_OFS_MULT, 1'b1, m);
			for (int v = 0; v < 8; v++) begin
				ahb(EBWSG_OFS_CONFIG, 1'b1, v);
				acc(EBWSG_SP_PROG, 16'h0000, 1'b0, v << m);
			end
		end
		ahb(EBWSG_OFS_MULT, 1'b1, 32'h0);
		ahb(EBWSG_OFS_CONFIG, 1'b1, 32'h8010);
		xmsb <= 1'b1;
		acc(EBWSG_SP_PROG, 16'h0000, 1'b0, 2);
		xmsb <= 1'b0;
		acc(EBWSG_SP_PROG, 16'hFFFF, 1'b0, 0);
		ahb(EBWSG_OFS_CONFIG, 1'b1, 32'h3);
		loop_en <= 1'b1;
		acc(EBWSG_SP_PROG, 16'h0000, 1'b0, 3);
		loop_en <= 1'b0;
		stall <= 4'h8;
		for (int v = 0; v < 3; v++) begin
			ahb(EBWSG_OFS_CONFIG, 1'b1, v);
			acc(EBWSG_SP_PROG, 16'h0000, 1'b0, v);
		end
		flag(3'h1, 1'b1);
		flag(3'h2, 1'b0);
		flag(3'h1, 1'b1);
		flag(3'h4, 1'b0);
		freeze();
		flag(3'h5, 1'b1);
		ahb(EBWSG_OFS_STATUS, 1'b0, 32'h0);
		chk(d, (32'h1 << EBWSG_ST_FLAG) | (32'h1 << EBWSG_ST_MSC));
		test_done();
	end
endmodule
